// ==== src/gnc_pkg.sv ====
// Package of constants and types for the graphics notifier and context block
package gnc_pkg;

	// ------------------------------------------------------------
	// Method codes
	// ------------------------------------------------------------
	localparam logic [11:0] MTHD_OBJ_OPTIONS = 12'h000;
	localparam logic [11:0] MTHD_NOP         = 12'h100;
	localparam logic [11:0] MTHD_NOTIFY      = 12'h104;
	localparam logic [11:0] MTHD_BUF_BIND    = 12'h180;
	localparam logic [11:0] MTHD_ROP         = 12'h300;
	localparam logic [11:0] MTHD_CHROMA      = 12'h304;
	localparam logic [11:0] MTHD_PLANE       = 12'h308;
	localparam logic [11:0] MTHD_BLEND       = 12'h30c;
	localparam logic [11:0] MTHD_CLIP_POS    = 12'h310;
	localparam logic [11:0] MTHD_CLIP_SIZE   = 12'h314;
	localparam logic [11:0] MTHD_PAT_SHAPE   = 12'h318;
	localparam logic [11:0] MTHD_PAT_COLOR0  = 12'h31c;
	localparam logic [11:0] MTHD_PAT_COLOR1  = 12'h320;
	localparam logic [11:0] MTHD_PAT_BITS_LO = 12'h324;
	localparam logic [11:0] MTHD_PAT_BITS_HI = 12'h328;
	localparam logic [11:0] MTHD_SURF_BASE   = 12'h330;

	// ------------------------------------------------------------
	// Record layout
	// ------------------------------------------------------------
	localparam logic [7:0] REC_STRIDE      = 8'h10;
	localparam logic [7:0] REC_OFS_TIME_LO = 8'h00;
	localparam logic [7:0] REC_OFS_TIME_HI = 8'h04;
	localparam logic [7:0] REC_OFS_ERRWORD = 8'h08;
	localparam logic [7:0] REC_OFS_DONE    = 8'h0c;
	localparam logic [7:0] REC_COPY_BASE   = 8'h10;

	// ------------------------------------------------------------
	// Notify types and limits
	// ------------------------------------------------------------
	localparam logic [3:0] NTYPE_WRITE     = 4'h0;
	localparam logic [3:0] NTYPE_WRITE_INT = 4'h1;
	localparam logic [3:0] NTYPE_MAX_OLD   = 4'hf;
	localparam logic [3:0] NTYPE_MAX_NEW   = 4'h1;

	// ------------------------------------------------------------
	// Error cause codes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CAUSE_NONE          = 3'h0,
		CAUSE_INVALID_NOTIFY = 3'h1,
		CAUSE_INVALID_VALUE = 3'h2,
		CAUSE_DOUBLE_NOTIFY = 3'h3,
		CAUSE_CTXSW_NOTIFY  = 3'h4,
		CAUSE_SUBCTX_SWITCH = 3'h5,
		CAUSE_NOTIFY_DONE   = 3'h6
	} gnc_cause_t;

	// Reset values
	localparam logic [7:0] ROP_RESET = 8'hcc;

endpackage

// ==== src/gnc_notifier.sv ====
// Notifier write engine and channel context for the graphics method interpreter
`timescale 1ns/100ps
// What this block does
// - Writes each record as 16 bytes
// - Timestamp at offset zero from timer
// - Big-endian mode swaps timestamp bytes
// - Word at 0x8 always written zero
// - Fields ascend; done word written last
// - Notify-requested records; copy record always
// - All records go to bound buffer
// - Record 0 at 0x00, copy 0x10
// - Notify only arms pending and type
// - Error on notify then bind/switch
// - Notify 0x104 types 0,1; 2..15 only with OLD_VARIANT
// - Notify needs permit flag else interrupt
// - Subcontext mismatch raises context interrupt
// - Channel context kept over switches
// - Pending state lost on switch/bind
// - Holds rop, chroma, plane, blend, clip
// - Pattern shape, two colours, 64 bits
// - Four copies of surface setup
// - After method, write pending record, clear
// - Double notify, invalid type raise errors
module gnc_notifier
	import gnc_pkg::*;
#(
	parameter int  DATA_W  = 32,
	parameter bit  OLD_VARIANT = 1'b0
) (
	input  wire logic              clock,
	input  wire logic              resetn,
	input  wire logic              clockEnable,
	// Method stream from the command fifo
	input  wire logic              mthdValid,
	output logic                   mthdReady,
	input  wire logic [11:0]       mthdAddr,
	input  wire logic [DATA_W-1:0] mthdData,
	input  wire logic              subchSwitch,
	input  wire logic              objBind,
	input  wire logic              copyDone,
	input  wire logic              bigEndian,
	input  wire logic [31:0]       timeLow,
	input  wire logic [31:0]       timeHigh,
	// Memory write port
	output logic                   memWrite,
	output logic [31:0]            memAddr,
	output logic [31:0]            memData,
	input  wire logic              memReady,
	// Interrupt outputs
	output logic                   intrValid,
	output logic [2:0]             intrCause,
	// Register port
	input  wire logic [7:0]        regAddr,
	input  wire logic [31:0]       regWdata,
	input  wire logic              regWrite,
	input  wire logic              regRead,
	output logic [31:0]            regRdata
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_W0, ST_W1, ST_W2, ST_W3} gnc_wstate_t;

	localparam logic [7:0] REG_STATUS    = 8'h00;
	localparam logic [7:0] REG_BUF_BASE  = 8'h04;
	localparam logic [7:0] REG_ROP       = 8'h08;
	localparam logic [7:0] REG_SUBCTX    = 8'h0c;
	localparam logic [7:0] REG_CTRL      = 8'h10;
	localparam logic [7:0] REG_DMA_EN    = 8'h14;

	typedef struct packed {
		gnc_wstate_t      wst;
		logic             pending;
		logic [3:0]       ntype;
		logic             wrInt;
		logic [7:0]       recOfs;
		logic [63:0]      stamp;
		logic             copyReq;
		logic [31:0]      bufBase;
		logic             permit;
		logic             objSubctx;
		logic             curSubctx;
		logic             dmaMethodsEn;
		logic [7:0]       rop;
		logic [31:0]      chroma;
		logic [31:0]      plane;
		logic [31:0]      blend;
		logic [31:0]      clipPos;
		logic [31:0]      clipSize;
		logic [1:0]       patShape;
		logic [31:0]      patColor0;
		logic [31:0]      patColor1;
		logic [63:0]      patBits;
		logic [3:0][31:0] surfBase;
		logic [1:0]       surfSel;
		logic             memWrite;
		logic [31:0]      memAddr;
		logic [31:0]      memData;
		logic             intrValid;
		logic [2:0]       intrCause;
		logic [31:0]      regRdata;
		logic [7:0]       errCount;
		logic             ready;
	} gnc_state_t;

	gnc_state_t s_q;
	gnc_state_t s_d;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] swap32(input logic [31:0] w);
		swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	function automatic logic isMthd(input logic [11:0] a, input logic [11:0] m);
		isMthd = (a == m);
	endfunction

	logic       busy;
	logic       take;
	logic [3:0] typeMax;
	logic [3:0] pType;

	// Busy until the last record word is accepted
	assign busy    = (s_q.wst != ST_IDLE) || s_q.memWrite;
	assign typeMax = OLD_VARIANT ? NTYPE_MAX_OLD : NTYPE_MAX_NEW;
	assign pType   = mthdData[3:0];
	assign take    = mthdValid && s_q.ready;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.intrValid = 1'b0;
		s_d.intrCause = CAUSE_NONE;

		// Register port
		if (regWrite) begin
			unique case (regAddr)
				REG_BUF_BASE: s_d.bufBase = regWdata;
				REG_ROP:      s_d.rop = regWdata[7:0];
				REG_SUBCTX:   s_d.curSubctx = regWdata[0];
				REG_CTRL:     s_d.surfSel = regWdata[1:0];
				REG_DMA_EN:   s_d.dmaMethodsEn = regWdata[0];
				default:      ;
			endcase
		end
		if (regRead) begin
			unique case (regAddr)
				REG_STATUS:   s_d.regRdata = {16'h0000, s_q.errCount, 2'b00, s_q.curSubctx,
					s_q.ntype, s_q.pending};
				REG_BUF_BASE: s_d.regRdata = s_q.bufBase;
				REG_ROP:      s_d.regRdata = {24'h000000, s_q.rop};
				REG_SUBCTX:   s_d.regRdata = {31'h0, s_q.curSubctx};
				REG_CTRL:     s_d.regRdata = {30'h0, s_q.surfSel};
				REG_DMA_EN:   s_d.regRdata = {31'h0, s_q.dmaMethodsEn};
				default:      s_d.regRdata = 32'h00000000;
			endcase
		end

		if (copyDone) begin
			s_d.copyReq = 1'b1;
		end

		// Subchannel switch or object bind
		if (subchSwitch || objBind) begin
			if (s_q.pending) begin
				s_d.intrValid = 1'b1;
				s_d.intrCause = CAUSE_CTXSW_NOTIFY;
				s_d.errCount  = s_q.errCount + 8'h01;
			end
			s_d.pending = 1'b0;
			s_d.ntype   = NTYPE_WRITE;
			// Channel context left untouched here
		end

		if (take) begin
			if (isMthd(mthdAddr, MTHD_NOTIFY)) begin
				if (!s_q.permit) begin
					s_d.intrValid = 1'b1;
					s_d.intrCause = CAUSE_INVALID_NOTIFY;
					s_d.errCount  = s_q.errCount + 8'h01;
				end else if (mthdData > {{(DATA_W-4){1'b0}}, typeMax}) begin
					s_d.intrValid = 1'b1;
					s_d.intrCause = CAUSE_INVALID_VALUE;
					s_d.errCount  = s_q.errCount + 8'h01;
				end else if (s_q.pending) begin
					s_d.intrValid = 1'b1;
					s_d.intrCause = CAUSE_DOUBLE_NOTIFY;
					s_d.errCount  = s_q.errCount + 8'h01;
				end else begin
					s_d.pending = 1'b1;
					s_d.ntype   = pType;
				end
			end else if (isMthd(mthdAddr, MTHD_BUF_BIND)) begin
				if (s_q.pending) begin
					s_d.intrValid = 1'b1;
					s_d.intrCause = CAUSE_DOUBLE_NOTIFY;
					s_d.errCount  = s_q.errCount + 8'h01;
				end else if (s_q.dmaMethodsEn) begin
					s_d.bufBase = mthdData[31:0];
				end else begin
					s_d.intrValid = 1'b1;
					s_d.intrCause = CAUSE_INVALID_VALUE;
					s_d.errCount  = s_q.errCount + 8'h01;
				end
			end else begin
				unique case (mthdAddr)
					MTHD_OBJ_OPTIONS: begin
						s_d.permit    = mthdData[0];
						s_d.objSubctx = mthdData[1];
						if (mthdData[1] != s_q.curSubctx) begin
							s_d.intrValid = 1'b1;
							s_d.intrCause = CAUSE_SUBCTX_SWITCH;
						end
					end
					MTHD_ROP:         s_d.rop = mthdData[7:0];
					MTHD_CHROMA:      s_d.chroma = mthdData[31:0];
					MTHD_PLANE:       s_d.plane = mthdData[31:0];
					MTHD_BLEND:       s_d.blend = mthdData[31:0];
					MTHD_CLIP_POS:    s_d.clipPos = mthdData[31:0];
					MTHD_CLIP_SIZE:   s_d.clipSize = mthdData[31:0];
					MTHD_PAT_SHAPE:   s_d.patShape = mthdData[1:0];
					MTHD_PAT_COLOR0:  s_d.patColor0 = mthdData[31:0];
					MTHD_PAT_COLOR1:  s_d.patColor1 = mthdData[31:0];
					MTHD_PAT_BITS_LO: s_d.patBits[31:0] = mthdData[31:0];
					MTHD_PAT_BITS_HI: s_d.patBits[63:32] = mthdData[31:0];
					MTHD_SURF_BASE:   s_d.surfBase[s_q.surfSel] = mthdData[31:0];
					default:          ;
				endcase
				if (s_q.pending) begin
					s_d.wst     = ST_W0;
					s_d.recOfs  = (s_q.ntype == NTYPE_WRITE_INT) ? 8'h00 :
						8'({4'h0, s_q.ntype} * REC_STRIDE);
					s_d.wrInt   = (s_q.ntype == NTYPE_WRITE_INT);
					s_d.stamp   = {timeHigh, timeLow};
					s_d.pending = 1'b0;
				end
			end
		end else if (!busy && s_q.copyReq) begin
			s_d.wst     = ST_W0;
			s_d.recOfs  = REC_COPY_BASE;
			s_d.wrInt   = 1'b0;
			s_d.stamp   = {timeHigh, timeLow};
			s_d.copyReq = copyDone;
		end

		// Record writer, fields in ascending order
		if (s_q.memWrite && memReady) begin
			s_d.memWrite = 1'b0;
		end
		if (!s_q.memWrite || memReady) begin
			unique case (s_q.wst)
				ST_IDLE: ;
				ST_W0: begin
					s_d.memWrite = 1'b1;
					s_d.memAddr  = s_q.bufBase + {24'h0, s_q.recOfs + REC_OFS_TIME_LO};
					s_d.memData  = bigEndian ? swap32(s_q.stamp[63:32]) : s_q.stamp[31:0];
					s_d.wst      = ST_W1;
				end
				ST_W1: begin
					s_d.memWrite = 1'b1;
					s_d.memAddr  = s_q.bufBase + {24'h0, s_q.recOfs + REC_OFS_TIME_HI};
					s_d.memData  = bigEndian ? swap32(s_q.stamp[31:0]) : s_q.stamp[63:32];
					s_d.wst      = ST_W2;
				end
				ST_W2: begin
					s_d.memWrite = 1'b1;
					s_d.memAddr  = s_q.bufBase + {24'h0, s_q.recOfs + REC_OFS_ERRWORD};
					s_d.memData  = 32'h00000000;
					s_d.wst      = ST_W3;
				end
				ST_W3: begin
					s_d.memWrite = 1'b1;
					s_d.memAddr  = s_q.bufBase + {24'h0, s_q.recOfs + REC_OFS_DONE};
					s_d.memData  = 32'h00000000;
					s_d.wst      = ST_IDLE;
					if (s_q.wrInt) begin
						s_d.intrValid = 1'b1;
						s_d.intrCause = CAUSE_NOTIFY_DONE;
					end
				end
			endcase
		end

		// Registered ready: no record active or queued next cycle
		s_d.ready = (s_d.wst == ST_IDLE) && !s_d.memWrite && !s_d.copyReq;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
			s_q.wst <= ST_IDLE;
			s_q.rop <= ROP_RESET;
			s_q.dmaMethodsEn <= 1'b1;
			s_q.ready <= 1'b1;
		end else if (clockEnable) begin
			s_q <= s_d;
		end
	end

	assign mthdReady = s_q.ready;
	assign memWrite  = s_q.memWrite;
	assign memAddr   = s_q.memAddr;
	assign memData   = s_q.memData;
	assign intrValid = s_q.intrValid;
	assign intrCause = s_q.intrCause;
	assign regRdata  = s_q.regRdata;

endmodule // gnc_notifier

// ==== verif/gnc_notifier_assertions.sv ====
// Port-level assertions for the notifier block
`timescale 1ns/100ps
module gnc_notifier_checker
	import gnc_pkg::*;
#(
	parameter int DATA_W      = 32,
	parameter bit OLD_VARIANT = 1'b0
) (
	input wire logic              clock,
	input wire logic              resetn,
	input wire logic              clockEnable,
	input wire logic              mthdValid,
	input wire logic              mthdReady,
	input wire logic [11:0]       mthdAddr,
	input wire logic [DATA_W-1:0] mthdData,
	input wire logic              memWrite,
	input wire logic [31:0]       memAddr,
	input wire logic [31:0]       memData,
	input wire logic              memReady,
	input wire logic              intrValid,
	input wire logic [2:0]        intrCause
);
	logic        noteTaken;
	logic [31:0] lastAddr;

	assign noteTaken = mthdValid && mthdReady && clockEnable && mthdAddr == MTHD_NOTIFY;

	// Address of the last accepted record word
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			lastAddr <= 32'h0;
		end else if (memWrite && memReady && clockEnable) begin
			lastAddr <= memAddr;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!resetn);

	// ------------------------------------------------------------
	// Record writes and errors
	// ------------------------------------------------------------
	a_word_held: assert property (memWrite && !memReady |=> memWrite && $stable(memAddr) && $stable(memData))
		else $error("record word changed before accept");
	a_error_word_zero: assert property (memWrite && memAddr[3:0] == 4'h8 |-> memData == 32'h0)
		else $error("word 8 not zero");
	a_done_word_zero: assert property (memWrite && memAddr[3:0] == 4'hc |-> memData == 32'h0)
		else $error("word c not zero");
	a_addr_ascend: assert property (memWrite && memAddr[3:0] != 4'h0 |-> memAddr == lastAddr + 32'h4)
		else $error("record words out of order");
	a_record_start: assert property ($rose(memWrite) |-> memAddr[3:0] == 4'h0)
		else $error("record not started at word 0");
	a_notify_arms: assert property (noteTaken |=> !memWrite [*2])
		else $error("write issued on notify alone");
	a_busy_stall: assert property (memWrite |-> !mthdReady)
		else $error("method accepted during record");
	a_bad_type: assert property (noteTaken && mthdData > (OLD_VARIANT ? 15 : 1) |=> intrValid
		&& intrCause inside {CAUSE_INVALID_NOTIFY, CAUSE_INVALID_VALUE})
		else $error("bad type not refused");
	a_cause_known: assert property (intrValid |-> intrCause != CAUSE_NONE && intrCause <= CAUSE_NOTIFY_DONE)
		else $error("interrupt without cause");
endmodule // gnc_notifier_checker

// ==== verif/gnc_fifo_model.sv ====
// Behavioural command fifo delivering methods and object selections
`timescale 1ns/100ps
module gnc_fifo_model
	import gnc_pkg::*;
(
	input  wire logic   clock,
	input  wire logic   mthdReady,
	output logic        mthdValid,
	output logic [11:0] mthdAddr,
	output logic [31:0] mthdData,
	output logic        subchSwitch,
	output logic        objBind
);
	initial begin
		mthdValid = 1'b0;
		mthdAddr = 12'h0;
		mthdData = 32'h0;
		subchSwitch = 1'b0;
		objBind = 1'b0;
	end

	// Hold the method until taken, then scramble the released bus
	task automatic send(input logic [11:0] a, input logic [31:0] d);
		logic r;
		mthdAddr <= a;
		mthdData <= d;
		mthdValid <= 1'b1;
		do begin
			@(negedge clock);
			r = mthdReady;
			@(posedge clock);
		end while (r !== 1'b1);
		mthdValid <= 1'b0;
		mthdAddr <= ~a;
		mthdData <= ~d;
		@(posedge clock);
	endtask

	task automatic select(input logic isBind, input logic [31:0] opts);
		if (isBind)
			objBind <= 1'b1;
		else
			subchSwitch <= 1'b1;
		@(posedge clock);
		objBind <= 1'b0;
		subchSwitch <= 1'b0;
		send(MTHD_OBJ_OPTIONS, opts);
	endtask
endmodule // gnc_fifo_model

// ==== verif/tb.sv ====
// Self-checking bench for the notifier and context block
`timescale 1ns/100ps
bind gnc_notifier gnc_notifier_checker #(.DATA_W(DATA_W), .OLD_VARIANT(OLD_VARIANT)) chk (.clock(clock),
	.resetn(resetn), .clockEnable(clockEnable), .mthdValid(mthdValid), .mthdReady(mthdReady), .mthdAddr(mthdAddr),
	.mthdData(mthdData), .memWrite(memWrite), .memAddr(memAddr), .memData(memData), .memReady(memReady),
	.intrValid(intrValid), .intrCause(intrCause));
module tb;
	import gnc_pkg::*;
	localparam logic [31:0] BASE = 32'h00001000;
	localparam logic [31:0] LO   = 32'h89abcdef;
	localparam logic [31:0] HI   = 32'h01234567;
	logic        clock, resetn, clockEnable, mthdValid, mthdReady, subchSwitch, objBind, copyDone, bigEndian;
	logic        memWrite, memReady, intrValid, regWrite, regRead;
	logic [11:0] mthdAddr;
	logic [31:0] mthdData, timeLow, timeHigh, memAddr, memData, regWdata, regRdata;
	logic [7:0]  regAddr;
	logic [2:0]  intrCause;
	logic [63:0] memQ[$];
	logic [2:0]  intrQ[$];
	int          errTotal, comparisons;

	gnc_notifier dut (.clock(clock), .resetn(resetn), .clockEnable(clockEnable), .mthdValid(mthdValid),
		.mthdReady(mthdReady), .mthdAddr(mthdAddr), .mthdData(mthdData), .subchSwitch(subchSwitch), .objBind(objBind),
		.copyDone(copyDone), .bigEndian(bigEndian), .timeLow(timeLow), .timeHigh(timeHigh), .memWrite(memWrite),
		.memAddr(memAddr), .memData(memData), .memReady(memReady), .intrValid(intrValid), .intrCause(intrCause),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
	gnc_fifo_model fifo (.clock(clock), .mthdReady(mthdReady), .mthdValid(mthdValid), .mthdAddr(mthdAddr),
		.mthdData(mthdData), .subchSwitch(subchSwitch), .objBind(objBind));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Collect accepted record words and interrupts
	always @(posedge clock) begin
		if (memWrite === 1'b1 && memReady === 1'b1)
			memQ.push_back({memAddr, memData});
		if (intrValid === 1'b1)
			intrQ.push_back(intrCause);
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		@(negedge clock);
		chk(regRdata, exp);
		@(posedge clock);
	endtask
	task automatic intr(input logic [2:0] c);
		for (int i = 0; i < 8 && intrQ.size() == 0; i++)
			@(posedge clock);
		chk({29'h0, intrQ.size() > 0 ? intrQ.pop_front() : 3'h7}, {29'h0, c});
	endtask
	task automatic rec(input logic [7:0] ofs, input logic [31:0] w0, input logic [31:0] w1);
		logic [63:0] e;
		for (int i = 0; i < 40 && memQ.size() < 4; i++)
			@(posedge clock);
		chk(32'(memQ.size()), 32'h4);
		for (int i = 0; i < 4 && memQ.size() > 0; i++) begin
			e = memQ.pop_front();
			chk(e[63:32], BASE + {24'h0, ofs} + 32'(4 * i));
			chk(e[31:0], i == 0 ? w0 : i == 1 ? w1 : 32'h0);
		end
	endtask
	task automatic quiet();
		repeat (10) @(posedge clock);
		chk(32'(memQ.size() + intrQ.size()), 32'h0);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		clockEnable = 1'b1;
		resetn = 1'b0;
		copyDone = 1'b0;
		bigEndian = 1'b0;
		memReady = 1'b1;
		timeLow = LO;
		timeHigh = HI;
		regAddr = 8'h0;
		regWdata = 32'h0;
		regWrite = 1'b0;
		regRead = 1'b0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		@(posedge clock);
		// ------------------------------------------------------------
		// Registers: reset value, readback, unmapped write
		// ------------------------------------------------------------
		rd(8'h08, 32'h000000cc);
		wr(8'h04, BASE);
		rd(8'h04, BASE);
		wr(8'h40, 32'hffffffff);
		wr(8'h08, 32'h0000005a);
		rd(8'h08, 32'h0000005a);
		$display("test regs done");
		// Plain notify, record after next method
		fifo.select(1'b1, 32'h1);
		fifo.send(MTHD_NOTIFY, 32'h0);
		rd(8'h00, 32'h1);
		fifo.send(MTHD_NOP, 32'h0);
		rec(8'h00, LO, HI);
		rd(8'h00, 32'h0);
		quiet();
		$display("test plain done");
		// Big-endian stamp, memory stalled, interrupt type
		bigEndian <= 1'b1;
		memReady <= 1'b0;
		fifo.send(MTHD_NOTIFY, 32'h1);
		fifo.send(MTHD_NOP, 32'h0);
		repeat (6) @(posedge clock);
		memReady <= 1'b1;
		rec(8'h00, 32'h67452301, 32'hefcdab89);
		intr(CAUSE_NOTIFY_DONE);
		bigEndian <= 1'b0;
		$display("test big done");
		copyDone <= 1'b1;
		@(posedge clock);
		copyDone <= 1'b0;
		rec(8'h10, LO, HI);
		$display("test copy done");
		// ------------------------------------------------------------
		// Error sequences
		// ------------------------------------------------------------
		fifo.send(MTHD_NOTIFY, 32'h2);
		intr(CAUSE_INVALID_VALUE);
		fifo.send(MTHD_NOTIFY, 32'h0);
		fifo.send(MTHD_NOTIFY, 32'h0);
		intr(CAUSE_DOUBLE_NOTIFY);
		fifo.send(MTHD_ROP, 32'h0000003c);
		rec(8'h00, LO, HI);
		fifo.send(MTHD_NOTIFY, 32'h0);
		fifo.select(1'b1, 32'h1);
		intr(CAUSE_CTXSW_NOTIFY);
		fifo.send(MTHD_NOP, 32'h0);
		quiet();
		fifo.send(MTHD_NOTIFY, 32'h0);
		fifo.select(1'b0, 32'h1);
		intr(CAUSE_CTXSW_NOTIFY);
		fifo.select(1'b1, 32'h3);
		intr(CAUSE_SUBCTX_SWITCH);
		fifo.select(1'b1, 32'h0);
		fifo.send(MTHD_NOTIFY, 32'h0);
		intr(CAUSE_INVALID_NOTIFY);
		rd(8'h08, 32'h0000003c);
		quiet();
		$display("test errors done");
		print_verdict();
	end

	initial begin
		repeat (5000) @(posedge clock);
		errTotal++;
		$display("MISMATCH %0t watchdog", $time);
		print_verdict();
	end
endmodule // tb
